// file: inc/fsps_pkg.sv
// Shared constants and types of the flash self-programming sequencer.
package fsps_pkg;

  // ==========================================================================
  // Control register layout
  // ==========================================================================
  localparam int CTL_IE_POS      = 7;
  localparam int CTL_BUSY_POS    = 6;
  localparam int CTL_REEN_POS    = 4;
  localparam int CTL_LOCK_POS    = 3;
  localparam int CTL_WRITE_POS   = 2;
  localparam int CTL_ERASE_POS   = 1;
  localparam int CTL_EN_POS      = 0;
  localparam logic [4:0] CMD_LOAD  = 5'h01;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_LOCK  = 5'h09;
  localparam logic [4:0] CMD_REEN  = 5'h11;

  // ==========================================================================
  // Addressing
  // ==========================================================================
  localparam int ADDR_W     = 16;
  localparam int WORD_W     = 7;
  localparam int PAGE_W     = 8;
  localparam int WORD_LSB   = 1;
  localparam int PAGE_LSB   = 8;
  localparam logic [7:0] HALT_PAGE_FIRST = 8'hE0;
  localparam logic [ADDR_W-1:0] RD_FUSE_LO  = 16'h0000;
  localparam logic [ADDR_W-1:0] RD_LOCK     = 16'h0001;
  localparam logic [ADDR_W-1:0] RD_FUSE_EXT = 16'h0002;
  localparam logic [ADDR_W-1:0] RD_FUSE_HI  = 16'h0003;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam logic [2:0] STORE_WINDOW = 3'h4;
  localparam logic [2:0] LOAD_WINDOW  = 3'h3;
  localparam real PROG_TIME_MS = 4.0;
  localparam real CLK_MHZ      = 250.0;
  localparam int  PROG_CYCLES  = int'(PROG_TIME_MS * CLK_MHZ * 1000.0);
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] LOCK_RESET = 8'hFF;

  typedef enum logic [2:0] {FSPS_IDLE, FSPS_ARMED, FSPS_ERASE, FSPS_WRITE, FSPS_LOCK} fsps_state_e;

endpackage : fsps_pkg

// file: logic/fsps_page_buffer.sv
// Temporary page buffer with per-word valid bits and registered read data.
`timescale 1ns/100ps
`default_nettype none
module fsps_page_buffer
  import fsps_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic              clearAll,
  input  wire logic              wrEn,
  input  wire logic [WORD_W-1:0] wrIdx,
  input  wire logic [15:0]       wrData,
  input  wire logic [WORD_W-1:0] rdIdx,
  output logic      [15:0]       rdData,
  output logic                   rdValid
);

  localparam int DEPTH = 1 << WORD_W;

  logic [15:0]      mem [DEPTH];
  logic [DEPTH-1:0] valid;

  // Erased words read as all ones, like blank flash.
  always_ff @(posedge core_clk)
  begin
    if (wrEn)
    begin
      mem[wrIdx] <= wrData;
    end
    rdData  <= valid[rdIdx] ? mem[rdIdx] : 16'hFFFF;
    if (sys_rst || clearAll)
    begin
      valid   <= '0;
      rdValid <= 1'b0;
    end
    else
    begin
      if (wrEn)
      begin
        valid[wrIdx] <= 1'b1;
      end
      rdValid <= valid[rdIdx];
    end
  end

endmodule : fsps_page_buffer
`default_nettype wire

// file: logic/fsps_sequencer.sv
// Self-programming sequencer: control register, command timing, buffer and lock/fuse readback.
//
// Function
// - Erase code written then store within four cycles starts page erase; data ignored.
// - Erase page comes only from the page index field of the pointer.
// - Erasing concurrent section keeps halting section readable; halting-section erase stalls CPU.
// - Load code plus store within four cycles writes data word at word index.
// - Page buffer clears after page write, on read re-enable, and on reset.
// - An EEPROM write during page loading discards the loaded buffer data.
// - Write code plus store within four cycles writes buffer to indexed page.
// - Writing concurrent section keeps halting section readable; halting-section write stalls CPU.
// - With interrupt enabled, ready interrupt is a level while store enable is zero.
// - Erase or write of a concurrent-section page blocks concurrent section reads and holds section busy flag.
// - Lock code plus store programs boot lock bits where data bits 5..2 are zero.
// - Lock programming keeps all flash readable and never stalls the CPU.
// - During EEPROM write, refuse all self-programming and fuse or lock readback.
// - Lock op plus store enable, pointer at lock address, load within three returns lock byte.
// - Lock op and store enable clear after readback, no load in three, no store in four; the code has no three-cycle clear, only the four-cycle one.
// - Readback returns fuse low at 0, extended fuse at 2, fuse high at 3.
// - Programmed fuse or lock bits read zero, unprogrammed bits read one.
// - A flash write in progress when reset arrives is completed, not aborted.
// - Control writes matching no valid five-bit command pattern are ignored.
// - Store enable stays set until an erase or write has finished.
`timescale 1ns/100ps
`default_nettype none
module fsps_sequencer
  import fsps_pkg::*;
#(
  parameter int PROG_COUNT = PROG_CYCLES
)
(
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic              ctrlWrite,
  input  wire logic [7:0]        ctrlWrData,
  output logic      [7:0]        program_store_ctrl,
  input  wire logic              storeOp,
  input  wire logic              loadOp,
  input  wire logic [ADDR_W-1:0] zPointer,
  input  wire logic [15:0]       storeData,
  output logic      [7:0]        loadData,
  output logic                   loadDataValid,
  input  wire logic              eeprom_write_busy,
  input  wire logic [7:0]        fuse_low_byte,
  input  wire logic [7:0]        fuse_high_byte,
  input  wire logic [7:0]        extended_fuse_byte,
  input  wire logic [1:0]        generalLock,
  output logic                   cpuHalt,
  output logic                   concurrentReadBlock,
  output logic                   readyIrq,
  output logic                   flashProgStart,
  output logic                   flashEraseOp,
  output logic      [PAGE_W-1:0] flashPage,
  output logic      [WORD_W-1:0] bufRdIdx,
  output logic      [15:0]       bufRdData,
  output logic                   bufRdValid,
  output logic      [5:0]        bootLock
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    fsps_state_e       state;
    logic              intEn;
    logic              busy;
    logic [4:0]        cmd;
    logic [2:0]        window;
    logic [31:0]       timer;
    logic              halt;
    logic [PAGE_W-1:0] page;
    logic [3:0]        lockBits;
    logic [3:0]        lockPending;
    logic              loading;
    logic [WORD_W-1:0] rdIdx;
    logic [7:0]        loadData;
    logic              loadValid;
    logic              progStart;
    logic              eraseOp;
  } fsps_regs_s;

  fsps_regs_s r;
  fsps_regs_s next_r;

  logic bufClear;
  logic bufWrite;

  fsps_page_buffer pageBuf (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .clearAll (bufClear),
    .wrEn     (bufWrite),
    .wrIdx    (zPointer[WORD_LSB +: WORD_W]),
    .wrData   (storeData),
    .rdIdx    (r.rdIdx),
    .rdData   (bufRdData),
    .rdValid  (bufRdValid)
  );

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb
  begin
    logic       armed;
    logic       validCmd;
    logic [7:0] rdByte;
    logic       progActive;
    next_r   = r;
    bufClear = 1'b0;
    bufWrite = 1'b0;
    armed    = (r.state == FSPS_ARMED);
    progActive = (r.state == FSPS_ERASE) || (r.state == FSPS_WRITE) || (r.state == FSPS_LOCK);
    validCmd = (ctrlWrData[4:0] == CMD_LOAD) || (ctrlWrData[4:0] == CMD_ERASE) ||
               (ctrlWrData[4:0] == CMD_WRITE) || (ctrlWrData[4:0] == CMD_LOCK) ||
               (ctrlWrData[4:0] == CMD_REEN);
    rdByte = 8'hFF;
    next_r.loadValid = 1'b0;
    next_r.progStart = 1'b0;
    next_r.rdIdx     = WORD_W'(r.rdIdx + 1'b1);

    // A write that is refused or carries no valid pattern leaves the enable as it was.
    if (ctrlWrite && validCmd && !eeprom_write_busy && (r.state == FSPS_IDLE))
    begin
      next_r.intEn = ctrlWrData[CTL_IE_POS];
    end

    case (r.state)
      FSPS_IDLE:
      begin
        // An EEPROM write between two page loads loses the words loaded so far.
        if (eeprom_write_busy && r.loading)
        begin
          bufClear       = 1'b1;
          next_r.loading = 1'b0;
        end
        // A disallowed pattern or an EEPROM write in progress keeps the sequencer idle and its command as is.
        if (ctrlWrite && validCmd && !eeprom_write_busy)
        begin
          next_r.state  = FSPS_ARMED;
          next_r.cmd    = ctrlWrData[4:0];
          next_r.window = '0;
        end
      end
      FSPS_ARMED:
      begin
        next_r.window = r.window + 3'h1;
        if (eeprom_write_busy)
        begin
          next_r.state = FSPS_IDLE;
          if (r.loading)
          begin
            bufClear       = 1'b1;
            next_r.loading = 1'b0;
          end
        end
        else if (loadOp && (r.cmd == CMD_LOCK) && (r.window < LOAD_WINDOW))
        begin
          case (zPointer)
            RD_FUSE_LO:  rdByte = fuse_low_byte;
            RD_LOCK:     rdByte = {2'b11, r.lockBits, generalLock};
            RD_FUSE_EXT: rdByte = extended_fuse_byte;
            RD_FUSE_HI:  rdByte = fuse_high_byte;
            default:     rdByte = 8'hFF;
          endcase
          next_r.loadData  = rdByte;
          next_r.loadValid = 1'b1;
          next_r.state     = FSPS_IDLE;
        end
        else if (storeOp && (r.window < STORE_WINDOW))
        begin
          case (r.cmd)
            CMD_LOAD:
            begin
              bufWrite       = 1'b1;
              next_r.loading = 1'b1;
              next_r.busy    = 1'b0;
              next_r.state   = FSPS_IDLE;
            end
            CMD_ERASE, CMD_WRITE:
            begin
              next_r.page      = zPointer[PAGE_LSB +: PAGE_W];
              next_r.halt      = zPointer[PAGE_LSB +: PAGE_W] >= HALT_PAGE_FIRST;
              next_r.busy      = zPointer[PAGE_LSB +: PAGE_W] < HALT_PAGE_FIRST;
              next_r.timer     = 32'(PROG_COUNT);
              next_r.progStart = 1'b1;
              next_r.eraseOp   = (r.cmd == CMD_ERASE);
              next_r.state     = (r.cmd == CMD_ERASE) ? FSPS_ERASE : FSPS_WRITE;
              next_r.rdIdx     = '0;
            end
            CMD_LOCK:
            begin
              next_r.lockPending = storeData[5:2];
              next_r.timer       = 32'(PROG_COUNT);
              next_r.halt        = 1'b0;
              next_r.state       = FSPS_LOCK;
            end
            CMD_REEN:
            begin
              bufClear       = 1'b1;
              next_r.loading = 1'b0;
              next_r.busy    = 1'b0;
              next_r.state   = FSPS_IDLE;
            end
            default:
            begin
              next_r.state = FSPS_IDLE;
            end
          endcase
        end
        else if (r.window == STORE_WINDOW - 3'h1)
        begin
          next_r.state = FSPS_IDLE;
        end
      end
      FSPS_ERASE, FSPS_WRITE, FSPS_LOCK:
      begin
        next_r.timer = r.timer - 32'h1;
        if (r.timer <= 32'h1)
        begin
          next_r.state = FSPS_IDLE;
          next_r.halt  = 1'b0;
          if (r.state == FSPS_WRITE)
          begin
            bufClear       = 1'b1;
            next_r.loading = 1'b0;
          end
          if (r.state == FSPS_LOCK)
          begin
            next_r.lockBits = r.lockBits & r.lockPending;
          end
        end
      end
      default:
      begin
        next_r.state = FSPS_IDLE;
      end
    endcase

    // A reset only ends an operation that is not yet programming the array.
    if (sys_rst && !progActive)
    begin
      next_r.state   = FSPS_IDLE;
      next_r.intEn   = 1'b0;
      next_r.loading = 1'b0;
      next_r.halt    = 1'b0;
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic powerUp;

  always_ff @(posedge core_clk)
  begin
    powerUp <= 1'b1;
    // Until the power-up flag has been set once, the state is loaded with its initial value.
    case (powerUp)
      1'b1:
      begin
        r <= next_r;
      end
      default:
      begin
        r          <= '0;
        r.lockBits <= LOCK_RESET[3:0];
      end
    endcase
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  logic storeEnable;

  assign storeEnable = (r.state != FSPS_IDLE);
  assign program_store_ctrl = {r.intEn, r.busy, 1'b0,
                               storeEnable & r.cmd[CTL_REEN_POS],
                               storeEnable & r.cmd[CTL_LOCK_POS],
                               storeEnable & r.cmd[CTL_WRITE_POS],
                               storeEnable & r.cmd[CTL_ERASE_POS],
                               storeEnable};
  assign readyIrq            = r.intEn && !storeEnable;
  assign cpuHalt             = r.halt;
  assign concurrentReadBlock = r.busy;
  assign loadData            = r.loadData;
  assign loadDataValid       = r.loadValid;
  assign flashProgStart      = r.progStart;
  assign flashEraseOp        = r.eraseOp;
  assign flashPage           = r.page;
  assign bufRdIdx            = r.rdIdx;
  assign bootLock            = {r.lockBits, generalLock};

endmodule : fsps_sequencer
`default_nettype wire

// file: sim/fsps_cpu_model.sv
// CPU core model issuing timed control, store and load sequences.
`timescale 1ns/100ps
`default_nettype none
module fsps_cpu_model (
  input  wire logic   core_clk,
  output logic        ctrlWrite,
  output logic [7:0]  ctrlWrData,
  output logic        storeOp,
  output logic        loadOp,
  output logic [15:0] zPointer,
  output logic [15:0] storeData
);
  initial
  begin
    {ctrlWrite, storeOp, loadOp} = 3'h0;
    ctrlWrData = 8'h00;
    zPointer = 16'h0000;
    storeData = 16'h0000;
  end
  // Op 0 stores, 1 loads, 2 stops after the control write; gap places the op in its window.
  task automatic run(input logic [7:0] c, input logic [15:0] z, input logic [15:0] d, input int gap, input int op);
    @(negedge core_clk);
    ctrlWrite = 1'b1;
    ctrlWrData = c;
    zPointer = z;
    storeData = d;
    @(negedge core_clk);
    ctrlWrite = 1'b0;
    repeat (gap) @(negedge core_clk);
    storeOp = (op == 0);
    loadOp = (op == 1);
    @(negedge core_clk);
    {storeOp, loadOp} = 2'h0;
    zPointer = ~z;
    storeData = ~d;
  endtask : run
endmodule : fsps_cpu_model
`default_nettype wire

// file: sim/fsps_monitor.sv
// Port checks of the flash self-programming sequencer.
`timescale 1ns/100ps
`default_nettype none
module fsps_monitor
  import fsps_pkg::*;
#(
  parameter int PROG_COUNT = PROG_CYCLES
)
(
  input wire logic              core_clk,
  input wire logic              sys_rst,
  input wire logic [7:0]        program_store_ctrl,
  input wire logic              storeOp,
  input wire logic              loadOp,
  input wire logic              eeprom_write_busy,
  input wire logic              loadDataValid,
  input wire logic              cpuHalt,
  input wire logic              concurrentReadBlock,
  input wire logic              readyIrq,
  input wire logic              flashProgStart,
  input wire logic [PAGE_W-1:0] flashPage
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_irq_level: assert property (readyIrq == (program_store_ctrl[7] && !program_store_ctrl[0]))
    else $error("irq level wrong");
  a_busy_flag: assert property (concurrentReadBlock == program_store_ctrl[6])
    else $error("busy flag differs from block");
  a_start_busy: assert property (flashProgStart |-> program_store_ctrl[0] && (concurrentReadBlock == (flashPage < HALT_PAGE_FIRST)))
    else $error("start without busy");
  a_enable_hold: assert property (flashProgStart |=> program_store_ctrl[0] [*8])
    else $error("store enable dropped early");
  a_start_cause: assert property (flashProgStart |-> $past(storeOp) && !$past(eeprom_write_busy))
    else $error("start without store");
  a_halt_page: assert property (flashProgStart |-> cpuHalt == (flashPage >= HALT_PAGE_FIRST))
    else $error("halt does not match page");
  a_load_cause: assert property (loadDataValid |-> $past(loadOp) && !$past(eeprom_write_busy))
    else $error("readback without load");
  a_reserved_zero: assert property (program_store_ctrl[5] == 1'b0)
    else $error("reserved bit set");
  c_halt: cover property (flashProgStart && cpuHalt);
  c_read: cover property (loadDataValid);
  c_irq: cover property (readyIrq);
endmodule : fsps_monitor
bind fsps_sequencer fsps_monitor #(.PROG_COUNT(PROG_COUNT)) u_fsps_monitor (.*);
`default_nettype wire

// file: sim/fsps_sequencer_tb.sv
// Self-checking testbench of the flash self-programming sequencer.
`timescale 1ns/100ps
`default_nettype none
module fsps_sequencer_tb;
  import fsps_pkg::*;
  localparam int PC = 20;
  localparam logic [7:0] BAD [4] = '{8'h07, 8'h13, 8'h1F, 8'h0B};
  logic              core_clk, sys_rst, eeprom_write_busy, loadDataValid, cpuHalt, concurrentReadBlock;
  logic              ctrlWrite, storeOp, loadOp, readyIrq, flashProgStart, flashEraseOp, bufRdValid;
  logic [7:0]        ctrlWrData, program_store_ctrl, loadData, fuse_low_byte, fuse_high_byte, extended_fuse_byte;
  logic [15:0]       zPointer, storeData, bufRdData, d;
  logic [PAGE_W-1:0] flashPage;
  logic [WORD_W-1:0] bufRdIdx, w;
  logic [1:0]        generalLock;
  logic [5:0]        bootLock;
  logic [3:0]        lockExp;
  logic [8:0]        got;
  logic [31:0]       seed = 32'h6C30BEF1;
  logic [31:0]       r;
  int                mismatches, checked;

  fsps_sequencer #(.PROG_COUNT(PC)) u_fsps_sequencer (.*);
  fsps_cpu_model u_fsps_cpu_model (.*);

  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(negedge core_clk)
    if (loadDataValid === 1'b1)
      got <= {1'b1, loadData};

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [7:0] exp_rd(input logic [1:0] a);
    case (a)
      2'h0: return fuse_low_byte;
      2'h1: return {2'b11, lockExp, generalLock};
      2'h2: return extended_fuse_byte;
      default: return fuse_high_byte;
    endcase
  endfunction : exp_rd
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick
  task automatic wait_idle();
    for (int i = 0; i < 60 && program_store_ctrl[0] !== 1'b0; i++) tick(1);
  endtask : wait_idle
  task automatic ld(input logic [6:0] x, input logic [15:0] v);
    u_fsps_cpu_model.run(8'h01, {8'h00, x, 1'b0}, v, rnd() % 4, 0);
    wait_idle();
  endtask : ld
  task automatic rd(input logic [1:0] a);
    got = 9'h000;
    u_fsps_cpu_model.run(8'h09, {14'h0, a}, 16'h0, rnd() % 3, 1);
    tick(1);
    chk("rd", got, {1'b1, exp_rd(a)});
    chk("en", program_store_ctrl[0], 1'b0);
  endtask : rd
  task automatic bufchk(input logic [6:0] x, input logic [15:0] v, input logic ok);
    for (int i = 0; i < 200 && bufRdIdx !== x; i++) tick(1);
    tick(1);
    chk("bufv", bufRdValid, ok);
    if (ok) chk("bufd", bufRdData, v);
  endtask : bufchk
  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out

  initial
  begin
    tick(5000);
    mismatches++;
    close_out();
  end
  initial
  begin
    r = rnd();
    {generalLock, extended_fuse_byte, fuse_high_byte, fuse_low_byte} = r[25:0];
    eeprom_write_busy = 1'b0;
    lockExp = 4'hF;
    got = 9'h000;
    sys_rst = 1'b1;
    tick(10);
    sys_rst = 1'b0;
    for (int a = 0; a < 4; a++) rd(a[1:0]);
    for (int i = 0; i < 4; i++)
    begin
      u_fsps_cpu_model.run(BAD[i], 16'h0, 16'h0, 0, 2);
      chk("bad", program_store_ctrl[0], 1'b0);
    end
    u_fsps_cpu_model.run(8'h09, 16'h0001, 16'h0, 0, 2);
    chk("arm", program_store_ctrl[0], 1'b1);
    tick(5);
    chk("exp", program_store_ctrl[0], 1'b0);
    $display("test readback and commands done");
    r = rnd();
    w = r[6:0];
    d = r[31:16];
    ld(w, d);
    ld(w + 7'h1, ~d);
    bufchk(w, d, 1'b1);
    bufchk(w + 7'h1, ~d, 1'b1);
    r = rnd();
    u_fsps_cpu_model.run(8'h85, {8'h10, r[7:0]}, r[31:16], int'(r[9:8]), 0);
    chk("go", flashProgStart, 1'b1);
    chk("pg", flashPage, 8'h10);
    chk("er", flashEraseOp, 1'b0);
    chk("halt", cpuHalt, 1'b0);
    chk("blk", concurrentReadBlock, 1'b1);
    chk("irq", readyIrq, 1'b0);
    tick(PC / 2);
    chk("en", program_store_ctrl[0], 1'b1);
    wait_idle();
    chk("irq", readyIrq, 1'b1);
    chk("blk", concurrentReadBlock, 1'b1);
    bufchk(w, d, 1'b0);
    u_fsps_cpu_model.run(8'h11, 16'h0, 16'h0, 0, 0);
    tick(1);
    chk("blk", concurrentReadBlock, 1'b0);
    $display("test page write done");
    r = rnd();
    u_fsps_cpu_model.run(8'h03, {3'h7, r[12:0]}, r[31:16], int'(r[14:13]), 0);
    chk("er", flashEraseOp, 1'b1);
    chk("pg", flashPage, {3'h7, r[12:8]});
    chk("halt", cpuHalt, 1'b1);
    wait_idle();
    chk("halt", cpuHalt, 1'b0);
    u_fsps_cpu_model.run(8'h11, 16'h0, 16'h0, 0, 0);
    u_fsps_cpu_model.run(8'h09, 16'h0001, 16'hFFF7, int'(r[1:0]), 0);
    lockExp = lockExp & 4'hD;
    chk("halt", cpuHalt, 1'b0);
    chk("blk", concurrentReadBlock, 1'b0);
    wait_idle();
    rd(2'h1);
    $display("test erase and lock done");
    ld(w, d);
    eeprom_write_busy = 1'b1;
    u_fsps_cpu_model.run(8'h03, 16'h1000, 16'h0, 0, 0);
    chk("go", flashProgStart, 1'b0);
    got = 9'h000;
    u_fsps_cpu_model.run(8'h09, 16'h0001, 16'h0, 0, 1);
    tick(1);
    chk("rd", got, 9'h000);
    eeprom_write_busy = 1'b0;
    bufchk(w, d, 1'b0);
    ld(w, d);
    u_fsps_cpu_model.run(8'h11, 16'h0, 16'h0, 0, 0);
    bufchk(w, d, 1'b0);
    u_fsps_cpu_model.run(8'h05, 16'h2000, 16'h0, 0, 0);
    tick(3);
    sys_rst = 1'b1;
    tick(1);
    sys_rst = 1'b0;
    tick(1);
    chk("en", program_store_ctrl[0], 1'b1);
    wait_idle();
    chk("en", program_store_ctrl[0], 1'b0);
    $display("test refusal and reset done");
    close_out();
  end
endmodule : fsps_sequencer_tb
`default_nettype wire
